//--- dv/rqp_checker.sv
`timescale 1ns/100ps
module rqp_checker #(
  parameter int unsigned CLK_KHZ  = 16,
  parameter int unsigned XTAL_KHZ = 16
) (
  // Clock and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        wake_request_n_i,
  input wire logic        ring_timer_gate_n_i,
  input wire logic        line_energy_in_i,
  input wire logic        carrier_present_i,
  input wire logic        demod_bit_i,
  input wire logic        osc_en_o,
  input wire logic        ring_en_o,
  input wire logic        demod_en_o,
  input wire logic        ring_valid_n_o,
  input wire logic        ring_valid_n_oe_o,
  input wire logic        carrier_valid_n_o,
  input wire logic        raw_data_out_o,
  input wire logic        validated_data_out_o
);
  localparam int UP = (CLK_KHZ / XTAL_KHZ) * (XTAL_KHZ * 1000 / 800);
  localparam int MS = CLK_KHZ;
  logic       sw_q;
  // Wide enough for the real clock rates, so the bounds never hit saturation
  logic [31:0] on_q;
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==================================================
  // Helpers
  // Software wake tracked at the taken edge, as the slave latches it
  always_ff @(posedge clk_i) begin
    if (rst_i)
      sw_q <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0])
      sw_q <= wb_dat_i[0];
  end
  always_ff @(posedge clk_i) begin
    on_q <= (rst_i || !osc_en_o) ? 32'h0 : on_q + {31'h0, on_q != 32'hffffffff};
    lo_q <= (rst_i || carrier_present_i) ? 32'h0 : lo_q + {31'h0, lo_q != 32'hffffffff};
    hi_q <= (rst_i || !carrier_present_i) ? 32'h0 : hi_q + {31'h0, hi_q != 32'hffffffff};
  end
  // ==================================================
  // Properties
  property p_active;
    (!wake_request_n_i)[*5] |-> osc_en_o && demod_en_o;
  endproperty
  a_active: assert property (p_active) else $error("wake low without full power");
  property p_standby;
    (wake_request_n_i && ring_timer_gate_n_i && !line_energy_in_i && !sw_q)[*5] |-> !osc_en_o && !demod_en_o;
  endproperty
  a_standby: assert property (p_standby) else $error("not in standby");
  property p_ring;
    (wake_request_n_i && !ring_timer_gate_n_i && !sw_q)[*5] |-> osc_en_o && ring_en_o && !demod_en_o;
  endproperty
  a_ring: assert property (p_ring) else $error("gate low wrong power");
  property p_energy;
    (wake_request_n_i && line_energy_in_i && !sw_q)[*5] |-> osc_en_o && ring_en_o && !demod_en_o;
  endproperty
  a_energy: assert property (p_energy) else $error("energy wrong power");
  property p_qual;
    $rose(ring_valid_n_oe_o) |-> on_q >= 47 * UP && !ring_valid_n_o;
  endproperty
  a_qual: assert property (p_qual) else $error("ring valid too early");
  property p_hold;
    (!osc_en_o)[*3] |-> !ring_valid_n_oe_o && ring_valid_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("ring valid in standby");
  property p_drop;
    $rose(carrier_valid_n_o) && demod_en_o |-> lo_q >= 8 * MS;
  endproperty
  a_drop: assert property (p_drop) else $error("carrier valid lost early");
  property p_acq;
    $fell(carrier_valid_n_o) |-> hi_q >= 13 * MS && hi_q <= 15 * MS + 8;
  endproperty
  a_acq: assert property (p_acq) else $error("carrier acquire time");
  property p_raw;
    (!carrier_valid_n_o)[*4] |-> raw_data_out_o == $past(demod_bit_i, 3);
  endproperty
  a_raw: assert property (p_raw) else $error("raw data not passed");
  property p_gate;
    carrier_valid_n_o[*2] |-> raw_data_out_o && validated_data_out_o;
  endproperty
  a_gate: assert property (p_gate) else $error("data not held high");
  c_qual: cover property ($rose(ring_valid_n_oe_o));
  c_carr: cover property ($fell(carrier_valid_n_o));
  c_act: cover property ($rose(demod_en_o));
endmodule

bind rqp_top rqp_checker #(.CLK_KHZ(CLK_KHZ), .XTAL_KHZ(XTAL_KHZ)) rqp_checker_inst (.*);

//--- dv/rqp_line_model.sv
`timescale 1ns/100ps
module rqp_line_model (
  // Control from bench
  input  wire logic       clk_i,
  input  wire logic       ring_on_i,
  input  wire logic       carr_on_i,
  input  wire logic [1:0] pat_i,
  // Comparator side
  output logic            level_o,
  output logic            energy_o,
  output logic            carrier_o,
  output logic            bit_o
);
  logic [3:0] ph_q = 4'h0;
  logic [3:0] bt_q = 4'h0;
  logic       alt_q = 1'b0;
  logic [7:0] sh_q = 8'h3a;
  always_ff @(posedge clk_i) begin
    ph_q <= ph_q + 4'h1;
    bt_q <= (bt_q == 4'hc) ? 4'h0 : bt_q + 4'h1;
    if (bt_q == 4'hc) begin
      alt_q <= ~alt_q;
      sh_q  <= {sh_q[6:0], sh_q[7]};
    end
  end
  // Ringing is not a clean level: three quarters duty
  // Pattern 3 without carrier gives a steady level, so saturation is exact
  assign level_o   = ring_on_i && (ph_q[3:2] != 2'h0 || pat_i == 2'h3);
  assign energy_o  = ring_on_i;
  assign carrier_o = carr_on_i;
  // Noise outside a carrier; about 1200 bps, mark is one
  assign bit_o = !carr_on_i ? ph_q[0] : (pat_i == 2'h0) ? alt_q : (pat_i == 2'h1) ? 1'b1 : sh_q[7];
endmodule

//--- dv/test_ring_qualify_power_control.sv
`timescale 1ns/100ps
module test_ring_qualify_power_control;
  // ==================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, wake_n = 1'b1, rt_n = 1'b1, csel = 1'b1;
  logic        ring_on = 1'b0, carr_on = 1'b0;
  logic [1:0]  pat = 2'h0;
  logic        lvl, nrg, car, dbit, osc, ren, den, rv_n, rv_oe, cv_n, cv_oe, raw, val;
  int          n_errors = 0, compares = 0;
  // Small rates: one oscillator tick per clock on the crystal, one per two clocks on the resonator; 1 ms is 16 clocks
  rqp_top #(.CLK_KHZ(16), .XTAL_KHZ(16), .RES_KHZ(8)) rqp_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wake_request_n_i(wake_n), .ring_timer_gate_n_i(rt_n), .line_energy_in_i(nrg),
    .ring_level_in_i(lvl), .clock_source_select_i(csel), .carrier_present_i(car),
    .demod_bit_i(dbit), .osc_en_o(osc), .ring_en_o(ren), .demod_en_o(den),
    .ring_valid_n_o(rv_n), .ring_valid_n_oe_o(rv_oe), .carrier_valid_n_o(cv_n),
    .carrier_valid_n_oe_o(cv_oe), .raw_data_out_o(raw), .validated_data_out_o(val));
  rqp_line_model rqp_line_model_inst (.clk_i(clk_i), .ring_on_i(ring_on), .carr_on_i(carr_on),
    .pat_i(pat), .level_o(lvl), .energy_o(nrg), .carrier_o(car), .bit_o(dbit));
  always #2.5 clk_i = ~clk_i;
  // ==================================================
  // Shared tasks
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
      chk("ack", 32'h0, 32'h1);
  endtask
  // Bounded wait on a level, judged when it ends
  task automatic wait_for(input string nm, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    // Looked at mid-cycle, where the outputs are settled
    @(negedge clk_i);
    while (s !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk(nm, {31'h0, s}, {31'h0, v});
    @(posedge clk_i);
  endtask
  // ==================================================
  // Scenarios
  task automatic t_regs;
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h0);
    bus(1'b1, 8'h04, 32'hffffffff);
    bus(1'b0, 8'h04, 32'h0);
    chk("status", q, 32'h100);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", q, 32'h0);
    rt_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    chk("mode ring", {30'h0, q[5:4]}, 32'h1);
    rt_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("osc off", {31'h0, osc}, 32'h0);
  endtask
  task automatic t_ring(input logic cs);
    csel <= cs;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    chk("clk sel", {31'h0, q[8]}, {31'h0, cs});
    rt_n    <= 1'b0;
    ring_on <= 1'b1;
    wait_for("ring valid", rv_n, 1'b0, 3000);
    pat <= 2'h3;
    repeat (2000) @(posedge clk_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("count sat", q, 32'd63);
    ring_on <= 1'b0;
    pat     <= 2'h0;
    wait_for("ring drop", rv_n, 1'b1, 1600);
    bus(1'b0, 8'h08, 32'h0);
    chk("count low", q, 32'd32);
    rt_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("count clr", q, 32'h0);
  endtask
  task automatic t_active;
    wake_n <= 1'b0;
    rt_n   <= 1'b0;
    repeat (8) @(posedge clk_i);
    rt_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("demod on", {31'h0, den}, 32'h1);
    repeat (240) @(posedge clk_i);
    carr_on <= 1'b1;
    wait_for("carrier", cv_n, 1'b0, 300);
    repeat (60) begin
      @(negedge clk_i);
      chk("preamble", {31'h0, val}, 32'h1);
    end
    @(posedge clk_i);
    carr_on <= 1'b0;
    repeat (64) @(posedge clk_i);
    carr_on <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("dropout", {31'h0, cv_n}, 32'h0);
    pat <= 2'h1;
    repeat (200) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    chk("status act", {26'h0, q[5:0]}, 32'h26);
    pat <= 2'h2;
    wait_for("cooked", val, 1'b0, 60);
    carr_on <= 1'b0;
    wait_for("carrier end", cv_n, 1'b1, 200);
    wake_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("standby", {31'h0, osc}, 32'h0);
  endtask
  task automatic t_sw;
    bus(1'b1, 8'h00, 32'h1);
    repeat (6) @(posedge clk_i);
    chk("sw wake", {31'h0, den}, 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    repeat (6) @(posedge clk_i);
    chk("sw sleep", {31'h0, osc}, 32'h0);
  endtask
  // ==================================================
  // Main and watchdog
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_ring(1'b1);
    t_active;
    t_sw;
    t_ring(1'b0);
    complete_run;
  end
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule

//--- rtl/rqp_cfg.svh
`ifndef RQP_CFG_SVH
`define RQP_CFG_SVH

// ==================================================
// Clock and oscillator rates
`define RQP_CLK_KHZ      200000
`define RQP_XTAL_KHZ     3579
`define RQP_RES_KHZ      455

// ==================================================
// Ring integrator
`define RQP_UP_HZ        800
`define RQP_DN_HZ        400
`define RQP_QUAL_CNT     48
`define RQP_DISQ_CNT     32
`define RQP_CNT_MAX      63

// ==================================================
// Carrier and data timing, in ms
`define RQP_ACQ_MS       14
`define RQP_DROP_MS      8
`define RQP_MARK_MS      10

// ==================================================
// Register map and fields
`define RQP_ADR_CTRL     8'h00
`define RQP_ADR_STATUS   8'h04
`define RQP_ADR_COUNT    8'h08
`define RQP_CTRL_WAKE    0
`define RQP_ST_RING      0
`define RQP_ST_CARR      1
`define RQP_ST_VALID     2
`define RQP_ST_MODE_LO   4
`define RQP_ST_CLKSEL    8

// ==================================================
// Reset value of the synchronised inputs
`define RQP_SYNC_RST     7'h60

`endif

//--- rtl/rqp_pkg.sv
package rqp_pkg;

  // ==================================================
  // Power modes
  typedef enum logic [1:0] {
    RQP_STANDBY,
    RQP_RING,
    RQP_ACTIVE
  } rqp_mode_t;

  // ==================================================
  // Synchronised pin levels
  typedef struct packed {
    logic wake_n;
    logic rt_n;
    logic energy;
    logic level;
    logic clk_sel;
    logic carrier;
    logic demod;
  } rqp_line_t;

endpackage

//--- rtl/rqp_top.sv
`timescale 1ns/100ps
`include "rqp_cfg.svh"


module rqp_top #(
  parameter int unsigned CLK_KHZ  = `RQP_CLK_KHZ,
  parameter int unsigned XTAL_KHZ = `RQP_XTAL_KHZ,
  parameter int unsigned RES_KHZ  = `RQP_RES_KHZ,
  parameter int unsigned CNT_W    = 6
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Line and control pins
  input  wire logic        wake_request_n_i,
  input  wire logic        ring_timer_gate_n_i,
  input  wire logic        line_energy_in_i,
  input  wire logic        ring_level_in_i,
  input  wire logic        clock_source_select_i,
  // Analog demodulator
  input  wire logic        carrier_present_i,
  input  wire logic        demod_bit_i,
  // Power enables
  output logic             osc_en_o,
  output logic             ring_en_o,
  output logic             demod_en_o,
  // Open-drain indicators
  output logic             ring_valid_n_o,
  output logic             ring_valid_n_oe_o,
  output logic             carrier_valid_n_o,
  output logic             carrier_valid_n_oe_o,
  // Data outputs
  output logic             raw_data_out_o,
  output logic             validated_data_out_o
);

  // ==================================================
  // Derived counts
  localparam logic [15:0] XTAL_PRE = 16'(CLK_KHZ / XTAL_KHZ - 1);
  localparam logic [15:0] RES_PRE  = 16'(CLK_KHZ / RES_KHZ - 1);
  localparam logic [15:0] XTAL_UP  = 16'(XTAL_KHZ * 1000 / `RQP_UP_HZ - 1);
  localparam logic [15:0] RES_UP   = 16'(RES_KHZ * 1000 / `RQP_UP_HZ - 1);
  localparam logic [15:0] XTAL_MS  = 16'(XTAL_KHZ - 1);
  localparam logic [15:0] RES_MS   = 16'(RES_KHZ - 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(`RQP_CNT_MAX);
  localparam logic [CNT_W-1:0] CNT_QUAL = CNT_W'(`RQP_QUAL_CNT);
  localparam logic [CNT_W-1:0] CNT_DISQ = CNT_W'(`RQP_DISQ_CNT);
  localparam logic [7:0]  ACQ_LAST  = 8'(`RQP_ACQ_MS - 1);
  localparam logic [7:0]  DROP_LAST = 8'(`RQP_DROP_MS);
  localparam logic [7:0]  MARK_LAST = 8'(`RQP_MARK_MS - 1);
  localparam logic [6:0]  SYNC_RST  = `RQP_SYNC_RST;

  // ==================================================
  // Input synchronisers
  logic [6:0]          async_in;
  logic [6:0]          sync_w;
  rqp_pkg::rqp_line_t  line_s;

  assign async_in = {wake_request_n_i, ring_timer_gate_n_i, line_energy_in_i,
                     ring_level_in_i, clock_source_select_i, carrier_present_i,
                     demod_bit_i};

  for (genvar g = 0; g < 7; g++) begin : g_sync
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q <= SYNC_RST[g];
        sync_q <= SYNC_RST[g];
      end else begin
        meta_q <= async_in[g];
        sync_q <= meta_q;
      end
    end
    assign sync_w[g] = sync_q;
  end

  assign line_s = rqp_pkg::rqp_line_t'(sync_w);

  // ==================================================
  // Power mode
  rqp_pkg::rqp_mode_t mode_q;
  rqp_pkg::rqp_mode_t mode_d;
  logic               ctrl_wake_q;
  logic               wake;
  logic               osc_on;

  assign wake   = ~line_s.wake_n | ctrl_wake_q;
  assign osc_on = (mode_q != rqp_pkg::RQP_STANDBY);

  always_comb begin
    if (wake) begin
      mode_d = rqp_pkg::RQP_ACTIVE;
    end else if (~line_s.rt_n | line_s.energy) begin
      mode_d = rqp_pkg::RQP_RING;
    end else begin
      mode_d = rqp_pkg::RQP_STANDBY;
    end
  end

  logic osc_en_q;
  logic ring_en_q;
  logic demod_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q     <= rqp_pkg::RQP_STANDBY;
      osc_en_q   <= 1'b0;
      ring_en_q  <= 1'b0;
      demod_en_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      osc_en_q   <= (mode_d != rqp_pkg::RQP_STANDBY);
      ring_en_q  <= (mode_d != rqp_pkg::RQP_STANDBY);
      demod_en_q <= (mode_d == rqp_pkg::RQP_ACTIVE);
    end
  end

  // ==================================================
  // Oscillator model and rate dividers
  // Rates follow the selected source, so a wrong select shows as wrong timing
  logic [15:0] pre_q;
  logic [15:0] up_q;
  logic [15:0] ms_q;
  logic        half_q;
  logic        osc_tick;
  logic        up_tick;
  logic        dn_tick;
  logic        ms_tick;
  logic [15:0] pre_last;
  logic [15:0] up_last;
  logic [15:0] ms_last;

  assign pre_last = line_s.clk_sel ? XTAL_PRE : RES_PRE;
  assign up_last  = line_s.clk_sel ? XTAL_UP : RES_UP;
  assign ms_last  = line_s.clk_sel ? XTAL_MS : RES_MS;
  assign osc_tick = osc_on & (pre_q >= pre_last);
  assign up_tick  = osc_tick & (up_q >= up_last);
  assign dn_tick  = up_tick & half_q;
  assign ms_tick  = osc_tick & (ms_q >= ms_last);

  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_on) begin
      pre_q <= 16'h0000;
    end else if (osc_tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_on) begin
      up_q   <= 16'h0000;
      half_q <= 1'b0;
    end else if (up_tick) begin
      up_q   <= 16'h0000;
      half_q <= ~half_q;
    end else if (osc_tick) begin
      up_q   <= up_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_on) begin
      ms_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_q <= 16'h0000;
    end else if (osc_tick) begin
      ms_q <= ms_q + 16'h0001;
    end
  end

  // ==================================================
  // Ring integrator
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_on) begin
      cnt_q <= '0;
    end else if (up_tick && line_s.level) begin
      if (cnt_q != CNT_MAX) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end else if (dn_tick && !line_s.level) begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // ==================================================
  // Ring qualification with hysteresis
  logic ring_q;
  logic ring_d;
  logic ring_n_q;

  always_comb begin
    ring_d = ring_q;
    if (!osc_on) begin
      ring_d = 1'b0;
    end else if (cnt_q >= CNT_QUAL) begin
      ring_d = 1'b1;
    end else if (cnt_q <= CNT_DISQ) begin
      ring_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ring_q   <= 1'b0;
      ring_n_q <= 1'b1;
    end else begin
      ring_q   <= ring_d;
      ring_n_q <= ~ring_d;
    end
  end

  // ==================================================
  // Carrier valid with acquisition and dropout hold
  // Millisecond granularity; the hold spans at least the full dropout time
  logic       carr_q;
  logic       carr_n_q;
  logic [7:0] acq_q;
  logic [7:0] drop_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || mode_q != rqp_pkg::RQP_ACTIVE) begin
      carr_q   <= 1'b0;
      carr_n_q <= 1'b1;
      acq_q    <= 8'h00;
      drop_q   <= 8'h00;
    end else if (!carr_q) begin
      drop_q <= 8'h00;
      if (!line_s.carrier) begin
        acq_q <= 8'h00;
      end else if (ms_tick) begin
        if (acq_q >= ACQ_LAST) begin
          carr_q   <= 1'b1;
          carr_n_q <= 1'b0;
          acq_q    <= 8'h00;
        end else begin
          acq_q <= acq_q + 8'h01;
        end
      end
    end else begin
      acq_q <= 8'h00;
      if (line_s.carrier) begin
        drop_q <= 8'h00;
      end else if (ms_tick) begin
        if (drop_q >= DROP_LAST) begin
          carr_q   <= 1'b0;
          carr_n_q <= 1'b1;
          drop_q   <= 8'h00;
        end else begin
          drop_q <= drop_q + 8'h01;
        end
      end
    end
  end

  // ==================================================
  // Validation: a steady mark run ends the alternating preamble
  logic       valid_q;
  logic [7:0] mark_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !carr_q) begin
      valid_q <= 1'b0;
      mark_q  <= 8'h00;
    end else if (!line_s.demod) begin
      mark_q <= 8'h00;
    end else if (ms_tick && !valid_q) begin
      if (mark_q >= MARK_LAST) begin
        valid_q <= 1'b1;
      end else begin
        mark_q <= mark_q + 8'h01;
      end
    end
  end

  // ==================================================
  // Data outputs
  // Bits pass unretimed, so the 1200 bps framing is the demodulator's
  logic raw_q;
  logic doc_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_q <= 1'b1;
      doc_q <= 1'b1;
    end else begin
      raw_q <= carr_q ? line_s.demod : 1'b1;
      doc_q <= (carr_q && valid_q) ? line_s.demod : 1'b1;
    end
  end

  // ==================================================
  // Wishbone slave
  logic        ack_q;
  logic [31:0] dat_q;
  logic        req;
  logic [31:0] status;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb begin
    status = 32'h0000_0000;
    status[`RQP_ST_RING]                   = ring_q;
    status[`RQP_ST_CARR]                   = carr_q;
    status[`RQP_ST_VALID]                  = valid_q;
    status[`RQP_ST_MODE_LO+1:`RQP_ST_MODE_LO] = mode_q;
    status[`RQP_ST_CLKSEL]                 = line_s.clk_sel;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_wake_q <= 1'b0;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `RQP_ADR_CTRL) begin
      ctrl_wake_q <= wb_dat_i[`RQP_CTRL_WAKE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req) begin
      unique case (wb_adr_i)
        `RQP_ADR_CTRL: begin
          dat_q <= {31'h0000_0000, ctrl_wake_q};
        end
        `RQP_ADR_STATUS: begin
          dat_q <= status;
        end
        `RQP_ADR_COUNT: begin
          dat_q <= 32'(cnt_q);
        end
        default: begin
          dat_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==================================================
  // Output drive
  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = dat_q;
  assign osc_en_o             = osc_en_q;
  assign ring_en_o            = ring_en_q;
  assign demod_en_o           = demod_en_q;
  assign ring_valid_n_o       = ring_n_q;
  assign ring_valid_n_oe_o    = ring_q;
  assign carrier_valid_n_o    = carr_n_q;
  assign carrier_valid_n_oe_o = carr_q;
  assign raw_data_out_o       = raw_q;
  assign validated_data_out_o = doc_q;

endmodule
